// [pkg/pcsl_pkg.sv]
// Constants for the PCM codec serial link
// How it works
// - Transmit starts on a transmit frame pulse, receive on a receive frame pulse.
// - Control bit 13 makes the transmit frame sync an input or an output.
// - Transmit done pulses when each word completes; receive done does too, except an async word whose stop bit is low.
// - Both directions are double buffered so words flow back to back without gaps.
// - Bit clocks shift the data and need only run during a transfer.
// - Receive data pin feeds the receive shift register through a two-flop synchronizer.
// - Asynchronous mode with software handshake lines on general bit pins.
package pcsl_pkg;
   localparam int unsigned WORD_W = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned GPIO_W = 16;
   localparam int unsigned FSD_BIT = 13;
   localparam int unsigned CTRL_W = 16;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned FS_OUT_PERIOD_US = 125;
   localparam int unsigned FS_OUT_CYCLES = FS_OUT_PERIOD_US * CLK_MHZ;
   localparam int unsigned ASYNC_DIV_DEFAULT = 1736;
endpackage

// [design/pcsl_fifo.sv]
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
`default_nettype none
module pcsl_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("DEPTH must be a power of two >= 2");
   end
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } pcsl_fifo_st_t;
   pcsl_fifo_st_t st_ff, nxt_st;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic push, pop;
   assign in_ready = (st_ff.wp - st_ff.rp) != (AW+1)'(DEPTH);
   assign out_valid = st_ff.wp != st_ff.rp;
   assign out_data = mem_ff[st_ff.rp[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb
   begin
      nxt_st = st_ff;
      if (push) nxt_st.wp = st_ff.wp + 1'b1;
      if (pop) nxt_st.rp = st_ff.rp + 1'b1;
   end
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn) st_ff <= '0;
      else st_ff <= nxt_st;
   end
   always_ff @(posedge clk_sys)
   begin
      if (push) mem_ff[st_ff.wp[AW-1:0]] <= in_data;
   end
endmodule // pcsl_fifo
`default_nettype wire

// [design/pcsl_link.sv]
// Serial port engine: framed sync mode, async mode, handshake pins
`timescale 1ns/100ps
`default_nettype none
module pcsl_link #(
   parameter int unsigned WORD_W = pcsl_pkg::WORD_W,
   parameter int unsigned FIFO_DEPTH = pcsl_pkg::FIFO_DEPTH,
   parameter int unsigned ASYNC_DIV = pcsl_pkg::ASYNC_DIV_DEFAULT,
   parameter int unsigned FS_OUT_CYCLES = pcsl_pkg::FS_OUT_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [pcsl_pkg::CTRL_W-1:0] serial_control_register,
   input wire logic async_mode,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [WORD_W-1:0] tx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [WORD_W-1:0] rx_data,
   output logic receive_done_interrupt,
   output logic transmit_done_interrupt,
   output logic rx_overrun,
   input wire logic transmit_bit_clock,
   input wire logic receive_bit_clock,
   input wire logic transmit_frame_sync_in,
   output logic transmit_frame_sync_out,
   output logic transmit_frame_sync_oe,
   input wire logic receive_frame_sync,
   output logic serial_tx_data,
   input wire logic serial_rx_data,
   input wire logic [pcsl_pkg::GPIO_W-1:0] general_bit_pins_in,
   output logic [pcsl_pkg::GPIO_W-1:0] general_bit_pins_out,
   output logic [pcsl_pkg::GPIO_W-1:0] general_bit_pins_oe,
   input wire logic [pcsl_pkg::GPIO_W-1:0] gpio_out_sw,
   input wire logic [pcsl_pkg::GPIO_W-1:0] gpio_dir_sw,
   output logic [pcsl_pkg::GPIO_W-1:0] gpio_in_sw
);
   localparam int unsigned BW = $clog2(WORD_W + 2);
   // Divider must also hold the one and a half bit wait after a start edge
   localparam int unsigned DW = $clog2(ASYNC_DIV + ASYNC_DIV / 2 + 1);
   localparam int unsigned FW = $clog2(FS_OUT_CYCLES + 1);
   if (WORD_W < 2 || ASYNC_DIV < 4 || FS_OUT_CYCLES < 2)
   begin : g_bad_params
      $error("pcsl_link parameters out of range");
   end
   typedef struct packed {
      logic [1:0] txc_s, rxc_s, fsx_s, fsr_s, rxd_s;
      logic txc_d, rxc_d;
      logic [pcsl_pkg::GPIO_W-1:0] gp_m, gp_s;
      logic tx_busy, tx_arm, tx_load;
      logic [WORD_W+1:0] tx_sh;
      logic [BW-1:0] tx_cnt;
      logic tx_line;
      logic rx_busy, rx_arm;
      logic [WORD_W-1:0] rx_sh;
      logic [BW-1:0] rx_cnt;
      logic [DW-1:0] tx_div, rx_div;
      logic rx_push;
      logic [WORD_W-1:0] rx_word;
      logic rx_done, tx_done, ovr;
      logic [FW-1:0] fs_cnt;
      logic fs_pulse;
   } pcsl_st_t;
   pcsl_st_t st_ff, nxt_st;
   logic fsd_out, txc_fall, rxc_fall, fsx_rise, fsr_rise;
   logic txf_valid, txf_ready, rxf_ready;
   logic [WORD_W-1:0] txf_data;
   assign fsd_out = serial_control_register[pcsl_pkg::FSD_BIT];
   assign txc_fall = st_ff.txc_d && !st_ff.txc_s[1];
   assign rxc_fall = st_ff.rxc_d && !st_ff.rxc_s[1];
   assign fsx_rise = fsd_out ? st_ff.fs_pulse : (st_ff.fsx_s[1] && !st_ff.tx_arm);
   assign fsr_rise = st_ff.fsr_s[1] && !st_ff.rx_arm;
   // Transmit side double buffer: FIFO holds next words while one shifts
   pcsl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_sys(clk_sys), .resetn(resetn),
      .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
      .out_valid(txf_valid), .out_ready(txf_ready), .out_data(txf_data)
   );
   pcsl_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_sys(clk_sys), .resetn(resetn),
      .in_valid(st_ff.rx_push), .in_ready(rxf_ready), .in_data(st_ff.rx_word),
      .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
   );
   assign txf_ready = st_ff.tx_load;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.txc_s = {st_ff.txc_s[0], transmit_bit_clock};
      nxt_st.rxc_s = {st_ff.rxc_s[0], receive_bit_clock};
      nxt_st.fsx_s = {st_ff.fsx_s[0], transmit_frame_sync_in};
      nxt_st.fsr_s = {st_ff.fsr_s[0], receive_frame_sync};
      nxt_st.rxd_s = {st_ff.rxd_s[0], serial_rx_data};
      nxt_st.txc_d = st_ff.txc_s[1];
      nxt_st.rxc_d = st_ff.rxc_s[1];
      nxt_st.gp_m = general_bit_pins_in;
      nxt_st.gp_s = st_ff.gp_m;
      nxt_st.tx_arm = fsd_out ? 1'b0 : st_ff.fsx_s[1];
      nxt_st.rx_arm = st_ff.fsr_s[1];
      nxt_st.tx_load = 1'b0;
      nxt_st.rx_push = 1'b0;
      nxt_st.rx_done = 1'b0;
      nxt_st.tx_done = 1'b0;
      nxt_st.ovr = 1'b0;
      // Frame pulse generator when transmit frame sync is driven out
      nxt_st.fs_pulse = 1'b0;
      if (fsd_out)
      begin
         if (st_ff.fs_cnt == FW'(FS_OUT_CYCLES - 1))
         begin
            nxt_st.fs_cnt = '0;
            nxt_st.fs_pulse = 1'b1;
         end
         else nxt_st.fs_cnt = st_ff.fs_cnt + 1'b1;
      end
      else nxt_st.fs_cnt = '0;
      // Transmitter
      if (async_mode)
      begin
         if (!st_ff.tx_busy)
         begin
            nxt_st.tx_line = 1'b1;
            if (txf_valid && !st_ff.tx_load)
            begin
               nxt_st.tx_load = 1'b1;
               nxt_st.tx_sh = {1'b1, txf_data, 1'b0};
               nxt_st.tx_cnt = BW'(WORD_W + 2);
               nxt_st.tx_div = '0;
               nxt_st.tx_busy = 1'b1;
            end
         end
         else if (st_ff.tx_div == '0)
         begin
            nxt_st.tx_div = DW'(ASYNC_DIV - 1);
            nxt_st.tx_line = st_ff.tx_sh[0];
            nxt_st.tx_sh = {1'b1, st_ff.tx_sh[WORD_W+1:1]};
            nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
            if (st_ff.tx_cnt == '0)
            begin
               nxt_st.tx_busy = 1'b0;
               nxt_st.tx_line = 1'b1;
               nxt_st.tx_done = 1'b1;
            end
         end
         else nxt_st.tx_div = st_ff.tx_div - 1'b1;
      end
      else
      begin
         if (fsx_rise && txf_valid && !st_ff.tx_load)
         begin
            nxt_st.tx_load = 1'b1;
            nxt_st.tx_sh = {2'b00, txf_data};
            nxt_st.tx_cnt = BW'(WORD_W);
            nxt_st.tx_busy = 1'b1;
         end
         else if (st_ff.tx_busy && txc_fall)
         begin
            nxt_st.tx_line = st_ff.tx_sh[WORD_W-1];
            nxt_st.tx_sh = {st_ff.tx_sh[WORD_W+1:WORD_W], st_ff.tx_sh[WORD_W-2:0], 1'b0};
            nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
            if (st_ff.tx_cnt == BW'(1))
            begin
               nxt_st.tx_busy = 1'b0;
               nxt_st.tx_done = 1'b1;
            end
         end
      end
      // Receiver
      if (async_mode)
      begin
         if (!st_ff.rx_busy)
         begin
            if (!st_ff.rxd_s[1])
            begin
               nxt_st.rx_busy = 1'b1;
               nxt_st.rx_div = DW'(ASYNC_DIV + ASYNC_DIV / 2 - 1);
               nxt_st.rx_cnt = BW'(WORD_W);
            end
         end
         else if (st_ff.rx_div == '0)
         begin
            nxt_st.rx_div = DW'(ASYNC_DIV - 1);
            if (st_ff.rx_cnt == '0)
            begin
               nxt_st.rx_busy = 1'b0;
               if (st_ff.rxd_s[1])
               begin
                  nxt_st.rx_word = st_ff.rx_sh;
                  nxt_st.rx_push = rxf_ready;
                  nxt_st.ovr = !rxf_ready;
                  nxt_st.rx_done = 1'b1;
               end
            end
            else
            begin
               nxt_st.rx_sh = {st_ff.rxd_s[1], st_ff.rx_sh[WORD_W-1:1]};
               nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
            end
         end
         else nxt_st.rx_div = st_ff.rx_div - 1'b1;
      end
      else
      begin
         if (fsr_rise)
         begin
            nxt_st.rx_busy = 1'b1;
            nxt_st.rx_cnt = BW'(WORD_W);
         end
         else if (st_ff.rx_busy && rxc_fall)
         begin
            nxt_st.rx_sh = {st_ff.rx_sh[WORD_W-2:0], st_ff.rxd_s[1]};
            nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
            if (st_ff.rx_cnt == BW'(1))
            begin
               nxt_st.rx_busy = 1'b0;
               nxt_st.rx_word = {st_ff.rx_sh[WORD_W-2:0], st_ff.rxd_s[1]};
               nxt_st.rx_push = rxf_ready;
               nxt_st.ovr = !rxf_ready;
               nxt_st.rx_done = 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_ff <= '0;
         st_ff.tx_line <= 1'b1;
      end
      else st_ff <= nxt_st;
   end
   assign serial_tx_data = st_ff.tx_line;
   assign receive_done_interrupt = st_ff.rx_done;
   assign transmit_done_interrupt = st_ff.tx_done;
   assign rx_overrun = st_ff.ovr;
   assign transmit_frame_sync_out = st_ff.fs_pulse;
   assign transmit_frame_sync_oe = fsd_out;
   // Handshake lines under software control
   assign general_bit_pins_out = gpio_out_sw;
   assign general_bit_pins_oe = gpio_dir_sw;
   assign gpio_in_sw = st_ff.gp_s;
endmodule // pcsl_link
`default_nettype wire

// [verification/pcsl_link_chk.sv]
// Port assertions for the serial link engine
`timescale 1ns/100ps
`default_nettype none
module pcsl_link_chk #(
   parameter int unsigned FS_OUT_CYCLES = pcsl_pkg::FS_OUT_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic async_mode,
   input wire logic [pcsl_pkg::CTRL_W-1:0] serial_control_register,
   input wire logic transmit_frame_sync_out,
   input wire logic transmit_frame_sync_oe,
   input wire logic serial_tx_data,
   input wire logic transmit_bit_clock,
   input wire logic receive_bit_clock,
   input wire logic transmit_done_interrupt,
   input wire logic receive_done_interrupt,
   input wire logic rx_overrun,
   input wire logic rx_valid,
   input wire logic [pcsl_pkg::GPIO_W-1:0] gpio_dir_sw,
   input wire logic [pcsl_pkg::GPIO_W-1:0] general_bit_pins_oe
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   wire fsd = serial_control_register[pcsl_pkg::FSD_BIT];
   // Cycles since the last frame pulse, cleared while the pin is an input
   int unsigned fs_gap;
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn) fs_gap <= '0;
      else if (!fsd) fs_gap <= '0;
      else if (transmit_frame_sync_out) fs_gap <= 32'h1;
      else fs_gap <= fs_gap + 32'h1;
   end
   fso_dir_a: assert property ($stable(fsd) |-> transmit_frame_sync_oe == fsd)
      else $error("frame sync enable differs from direction bit");
   fso_quiet_a: assert property (!fsd && !$past(fsd) |-> !transmit_frame_sync_out)
      else $error("frame pulse made while frame sync is an input");
   fso_period_a: assert property ($past(fsd) |-> transmit_frame_sync_out == (fs_gap == FS_OUT_CYCLES))
      else $error("frame pulse period wrong");
   txd_on_fall_a: assert property (!async_mode && $changed(serial_tx_data) |-> !transmit_bit_clock)
      else $error("transmit data moved while bit clock high");
   tdone_pulse_a: assert property (transmit_done_interrupt |=> !transmit_done_interrupt)
      else $error("transmit done longer than one cycle");
   rdone_late_a: assert property (!async_mode && receive_done_interrupt |-> !receive_bit_clock)
      else $error("receive done outside last bit");
   tx_idle_a: assert property (async_mode && transmit_done_interrupt |-> serial_tx_data)
      else $error("line not idle high after async word");
   rx_push_a: assert property (receive_done_interrupt && !rx_overrun |-> ##[0:2] rx_valid)
      else $error("received word not buffered");
   ovr_full_a: assert property (rx_overrun |-> rx_valid)
      else $error("overrun with room in buffer");
   gpio_dir_a: assert property ($stable(gpio_dir_sw) |-> general_bit_pins_oe == gpio_dir_sw)
      else $error("pin enables differ from direction");
endmodule // pcsl_link_chk
bind pcsl_link pcsl_link_chk #(.FS_OUT_CYCLES(FS_OUT_CYCLES)) u_pcsl_link_chk (.clk_sys, .resetn, .async_mode,
   .serial_control_register,
   .transmit_frame_sync_out, .transmit_frame_sync_oe, .serial_tx_data, .transmit_bit_clock,
   .receive_bit_clock, .transmit_done_interrupt, .receive_done_interrupt, .rx_overrun, .rx_valid,
   .gpio_dir_sw, .general_bit_pins_oe);
`default_nettype wire

// [verification/pcsl_codec.sv]
// Behavioural codec on the far side of the framed link
`timescale 1ns/100ps
`default_nettype none
module pcsl_codec (
   output logic frame_sync,
   output logic bit_clock,
   output logic pcm_out,
   input wire logic pcm_in
);
   initial
   begin
      frame_sync = 1'b0;
      bit_clock = 1'b1;
      pcm_out = 1'b1;
   end
   // Bit clock is the glue clock divided by 16
   localparam int unsigned GLUE_DIV = 16;
   localparam realtime GLUE_NS = 7.8125;
   localparam realtime HALF_NS = GLUE_NS * GLUE_DIV / 2;
   // One 8-bit slot, MSB first; clock idles high between slots
   task automatic slot(input logic [7:0] w, output logic [7:0] got);
      frame_sync = 1'b1;
      pcm_out = w[7];
      #HALF_NS frame_sync = 1'b0;
      #HALF_NS;
      for (int i = 7; i >= 0; i--)
      begin
         bit_clock = 1'b0;
         #HALF_NS bit_clock = 1'b1;
         got[i] = pcm_in;
         pcm_out = (i > 0) ? w[i-1] : ~w[0];
         #HALF_NS;
      end
   endtask
endmodule // pcsl_codec
`default_nettype wire

// [verification/test_pcsl_link.sv]
// Self-checking bench for the serial link
`timescale 1ns/100ps
`default_nettype none
module test_pcsl_link;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] serial_control_register = 16'h0000;
   logic tx_valid = 1'b0;
   logic async_mode = 1'b0;
   logic rx_ready = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic [15:0] general_bit_pins_in = 16'h0000, gpio_out_sw = 16'h0000, gpio_dir_sw = 16'h0000;
   logic tx_ready, rx_valid, rx_overrun, receive_done_interrupt, transmit_done_interrupt;
   logic transmit_frame_sync_out, transmit_frame_sync_oe, serial_tx_data, serial_rx_data, fs, bclk, pcm_line;
   logic [7:0] rx_data, got;
   logic [15:0] general_bit_pins_out, general_bit_pins_oe, gpio_in_sw;
   logic [7:0] sent [9];
   logic [7:0] heard [9];
   int miscompares = 0, num_checks = 0, seed = 83, cycles = 0, n_rd = 0, n_td = 0, n_ov = 0, n_fs = 0;
   pcsl_link #(.ASYNC_DIV(8), .FS_OUT_CYCLES(20)) u_pcsl_link (
      .clk_sys, .resetn, .serial_control_register, .async_mode, .tx_valid, .tx_ready, .tx_data,
      .rx_valid, .rx_ready, .rx_data, .receive_done_interrupt, .transmit_done_interrupt, .rx_overrun,
      .transmit_bit_clock(bclk), .receive_bit_clock(bclk), .transmit_frame_sync_in(fs),
      .transmit_frame_sync_out, .transmit_frame_sync_oe, .receive_frame_sync(fs), .serial_tx_data,
      .serial_rx_data, .general_bit_pins_in, .general_bit_pins_out, .general_bit_pins_oe, .gpio_out_sw,
      .gpio_dir_sw, .gpio_in_sw);
   pcsl_codec u_pcsl_codec (.frame_sync(fs), .bit_clock(bclk), .pcm_out(pcm_line), .pcm_in(serial_tx_data));
   // Asynchronous mode loops transmit data back into the receiver
   assign serial_rx_data = async_mode ? serial_tx_data : pcm_line;
   task automatic chk(input logic [15:0] a, input logic [15:0] e);
      num_checks++;
      if (a !== e)
      begin
         miscompares++;
         $display("mismatch t=%0t got %h exp %h", $time, a, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Event counters and hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      n_rd += int'(receive_done_interrupt);
      n_td += int'(transmit_done_interrupt);
      n_ov += int'(rx_overrun);
      n_fs += int'(transmit_frame_sync_out);
      if (cycles == 20000)
      begin
         miscompares++;
         complete_run();
      end
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      // Last words leave both data lines high, so the loopback sees no false start
      for (int i = 0; i < 9; i++)
      begin
         sent[i] = (i == 0) ? 8'h80 : 8'($random(seed)) | {7'h00, i == 7};
         heard[i] = (i == 7) ? 8'h01 : 8'($random(seed)) & {7'h7F, i != 8};
      end
      for (int i = 0; i < 8; i++)
      begin
         tx_valid <= 1'b1;
         tx_data <= sent[i];
         @(posedge clk_sys);
         chk(16'(tx_ready), 16'h0001);
      end
      tx_valid <= 1'b0;
      @(posedge clk_sys);
      chk(16'(tx_ready), 16'h0000);
      // Back-to-back slots with the reader stalled; last one overruns
      for (int i = 0; i < 9; i++)
      begin
         u_pcsl_codec.slot(heard[i], got);
         if (i < 8)
            chk(16'(got), 16'(sent[i]));
      end
      repeat (10) @(posedge clk_sys);
      chk(16'(n_td), 16'h0008);
      chk(16'(n_rd), 16'h0009);
      chk(16'(n_ov), 16'h0001);
      rx_ready <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         do @(posedge clk_sys); while (rx_valid !== 1'b1);
         chk(16'(rx_data), 16'(heard[i]));
      end
      rx_ready <= 1'b0;
      @(posedge clk_sys);
      chk(16'(rx_valid), 16'h0000);
      $display("framed transfer test done");
      serial_control_register <= 16'h2000;
      repeat (60) @(posedge clk_sys);
      chk(16'(transmit_frame_sync_oe), 16'h0001);
      chk(16'(n_fs >= 2 && n_fs <= 3), 16'h0001);
      serial_control_register <= 16'h0000;
      repeat (4) @(posedge clk_sys);
      chk(16'(transmit_frame_sync_oe), 16'h0000);
      $display("frame direction test done");
      repeat (4)
      begin
         gpio_out_sw <= 16'($random(seed));
         gpio_dir_sw <= 16'($random(seed));
         general_bit_pins_in <= 16'($random(seed));
         repeat (4) @(posedge clk_sys);
         chk(general_bit_pins_out, gpio_out_sw);
         chk(general_bit_pins_oe, gpio_dir_sw);
         chk(gpio_in_sw, general_bit_pins_in);
      end
      $display("handshake pin test done");
      async_mode <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 3; i++)
      begin
         sent[i] = (i == 1) ? 8'h00 : 8'($random(seed));
         tx_valid <= 1'b1;
         tx_data <= sent[i];
         @(posedge clk_sys);
      end
      tx_valid <= 1'b0;
      repeat (300) @(posedge clk_sys);
      chk(16'(n_td), 16'h000B);
      chk(16'(n_rd), 16'h000C);
      chk(16'(n_ov), 16'h0001);
      rx_ready <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         do @(posedge clk_sys); while (rx_valid !== 1'b1);
         chk(16'(rx_data), 16'(sent[i]));
      end
      rx_ready <= 1'b0;
      $display("asynchronous loopback test done");
      complete_run();
   end
endmodule // test_pcsl_link
`default_nettype wire
